/* core/meas_mode_config_pkg.sv */
// Constants and types for the measurement configuration registers
package meas_mode_config_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_SENSOR_STATUS   = 8'h01;
	localparam logic [7:0] ADDR_MEAS_PERIOD_HI  = 8'h02;
	localparam logic [7:0] ADDR_MEAS_PERIOD_LO  = 8'h03;
	localparam logic [7:0] ADDR_MEAS_MODE_CFG   = 8'h04;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_MEAS_PERIOD_HI   = 8'h00;
	localparam logic [7:0] RST_MEAS_PERIOD_LO   = 8'h3c;
	localparam logic [7:0] RST_MEAS_MODE_CFG    = 8'h24;

	// ==========================================================
	// Period limits, one unit is one second
	localparam int         PERIOD_UNIT_S        = 1;
	localparam logic [15:0] PERIOD_MAX          = 16'h0fff;
	localparam logic [15:0] PERIOD_MIN          = 16'h0005;
	localparam logic [7:0] PERIOD_HI_FIELD_MAX  = 8'h0f;
	localparam logic [7:0] PERIOD_LO_FORCED     = 8'h05;
	localparam logic [7:0] PERIOD_LO_RSVD_LIMIT = 8'h05;

	// ==========================================================
	// Status register bit positions
	localparam int         STS_PWM_PIN_BIT      = 6;
	localparam int         STS_COMM_ERR_BIT     = 3;
	localparam int         STS_COMM_ERR_CLR_BIT = 0;

	// ==========================================================
	// Field encodings
	localparam logic [1:0] OPM_IDLE             = 2'h0;
	localparam logic [1:0] OPM_SINGLE           = 2'h1;
	localparam logic [1:0] OPM_CONT             = 2'h2;
	localparam logic [1:0] OPM_RSVD             = 2'h3;
	localparam logic [1:0] BOC_OFF              = 2'h0;
	localparam logic [1:0] BOC_AUTO             = 2'h1;
	localparam logic [1:0] BOC_FORCED           = 2'h2;

	typedef struct packed {
		logic [1:0] rsvd;
		logic       pwm_sw_output_enable;
		logic       pwm_mode;
		logic [1:0] baseline_comp_select;
		logic [1:0] operating_mode_field;
	} mode_cfg_t;

	// Gray along idle -> single -> continuous
	typedef enum logic [1:0] {
		RUN_IDLE   = 2'b00,
		RUN_SINGLE = 2'b01,
		RUN_CONT   = 2'b11
	} run_state_t;

endpackage

/* core/meas_mode_config_regs.sv */
// Measurement period and mode configuration register bank
`timescale 1ns/100ps
`default_nettype none

module meas_mode_config_regs
(
	input  wire logic        I_CLK,
	input  wire logic        I_RESET_N,
	input  wire logic        i_WR_EN,
	input  wire logic        i_RD_EN,
	input  wire logic [7:0]  i_ADDR,
	input  wire logic [7:0]  i_WDATA,
	input  wire logic        i_PWM_DISABLE_PIN,
	input  wire logic        i_SINGLE_DONE,
	input  wire logic        i_FORCED_COMP_DONE,
	output logic      [7:0]  o_RDATA,
	output logic             o_RVALID,
	output logic      [15:0] o_ACTIVE_PERIOD,
	output logic             o_PERIOD_LATCHED,
	output logic             o_SINGLE_TRIGGER,
	output logic      [1:0]  o_OPERATING_MODE,
	output logic      [1:0]  o_BASELINE_COMP,
	output logic             o_PWM_MODE,
	output logic             o_PWM_OUT_ENABLE,
	output logic             o_COMM_ERROR
);

	// ==========================================================
	// Storage
	logic [7:0]                  meas_period_high;
	logic [7:0]                  meas_period_low;
	meas_mode_config_pkg::mode_cfg_t     meas_mode_config;
	meas_mode_config_pkg::run_state_t    run_state;
	meas_mode_config_pkg::run_state_t    next_run_state;
	logic                        comm_error_flag;
	logic                        pin_meta;
	logic                        pin_sync;
	logic                        pin_prev;

	// ==========================================================
	// Address decode
	wire logic wr_sts  = i_WR_EN
		&& (i_ADDR == meas_mode_config_pkg::ADDR_SENSOR_STATUS);
	wire logic wr_hi   = i_WR_EN
		&& (i_ADDR == meas_mode_config_pkg::ADDR_MEAS_PERIOD_HI);
	wire logic wr_lo   = i_WR_EN
		&& (i_ADDR == meas_mode_config_pkg::ADDR_MEAS_PERIOD_LO);
	wire logic wr_cfg  = i_WR_EN
		&& (i_ADDR == meas_mode_config_pkg::ADDR_MEAS_MODE_CFG);

	// ==========================================================
	// Period byte checks
	// Each write is judged alone against the stored other byte
	wire logic hi_bad  = wr_hi
		&& (i_WDATA > meas_mode_config_pkg::PERIOD_HI_FIELD_MAX);
	wire logic lo_bad  = wr_lo
		&& (i_WDATA < meas_mode_config_pkg::PERIOD_LO_RSVD_LIMIT);
	wire logic [7:0] next_lo = lo_bad
		? meas_mode_config_pkg::PERIOD_LO_FORCED : i_WDATA;
	wire logic [7:0] view_hi = wr_hi ? i_WDATA : meas_period_high;
	wire logic [7:0] view_lo = wr_lo ? next_lo : meas_period_low;
	// Period as it stands after this write
	wire logic signed [15:0] raw_period
		= $signed({view_hi, view_lo});
	wire logic signed [15:0] period_max
		= $signed(meas_mode_config_pkg::PERIOD_MAX);
	wire logic signed [15:0] period_min
		= $signed(meas_mode_config_pkg::PERIOD_MIN);
	// Negative values fall under the low limit as well
	wire logic [15:0] sat_period
		= (raw_period > period_max) ? meas_mode_config_pkg::PERIOD_MAX
		: (raw_period < period_min) ? meas_mode_config_pkg::PERIOD_MIN
		: raw_period;
	// Saturated value of a completed write counts as non-valid too
	wire logic period_bad = (wr_hi || wr_lo)
		&& (sat_period != raw_period);
	wire logic comm_err_set = hi_bad || lo_bad || period_bad;

	// ==========================================================
	// Mode field handling
	wire meas_mode_config_pkg::mode_cfg_t wr_cfg_val = i_WDATA;
	wire logic [1:0] wr_opm = wr_cfg_val.operating_mode_field;
	wire logic req_cont   = wr_cfg && (wr_opm == meas_mode_config_pkg::OPM_CONT);
	wire logic req_single = wr_cfg
		&& (wr_opm == meas_mode_config_pkg::OPM_SINGLE);
	// Reserved code 11 counts as idle
	wire logic req_idle = wr_cfg
		&& ((wr_opm == meas_mode_config_pkg::OPM_IDLE)
		|| (wr_opm == meas_mode_config_pkg::OPM_RSVD));
	wire logic enter_cont = req_cont
		&& (run_state == meas_mode_config_pkg::RUN_IDLE);
	wire logic single_end = (run_state == meas_mode_config_pkg::RUN_SINGLE)
		&& i_SINGLE_DONE;
	wire logic pwm_fall = pin_prev && !pin_sync;
	wire logic forced_end = i_FORCED_COMP_DONE
		&& (meas_mode_config.baseline_comp_select
		== meas_mode_config_pkg::BOC_FORCED);
	wire logic sts_clear = wr_sts
		&& i_WDATA[meas_mode_config_pkg::STS_COMM_ERR_CLR_BIT];

	// ==========================================================
	// Run state
	always_comb
	begin
		next_run_state = run_state;
		case (run_state)
			meas_mode_config_pkg::RUN_IDLE:
			begin
				if (req_single)
					next_run_state = meas_mode_config_pkg::RUN_SINGLE;
				else if (req_cont)
					next_run_state = meas_mode_config_pkg::RUN_CONT;
			end
			meas_mode_config_pkg::RUN_SINGLE:
			begin
				if (req_cont)
					next_run_state = meas_mode_config_pkg::RUN_CONT;
				else if (req_idle || single_end)
					next_run_state = meas_mode_config_pkg::RUN_IDLE;
			end
			meas_mode_config_pkg::RUN_CONT:
			begin
				if (req_idle)
					next_run_state = meas_mode_config_pkg::RUN_IDLE;
				else if (req_single)
					next_run_state = meas_mode_config_pkg::RUN_SINGLE;
			end
			default:
				next_run_state = meas_mode_config_pkg::RUN_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			run_state <= meas_mode_config_pkg::RUN_IDLE;
		else
			run_state <= next_run_state;
	end

	// ==========================================================
	// Disable pin synchroniser
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end
		else
		begin
			pin_meta <= i_PWM_DISABLE_PIN;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// ==========================================================
	// Period registers
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			meas_period_high <= meas_mode_config_pkg::RST_MEAS_PERIOD_HI;
			meas_period_low  <= meas_mode_config_pkg::RST_MEAS_PERIOD_LO;
		end
		else
		begin
			if (wr_hi)
				meas_period_high <= i_WDATA;
			if (wr_lo)
				meas_period_low <= next_lo;
		end
	end

	// ==========================================================
	// Mode configuration register
	// Forced-done and pin-fall updates win over a software write in the same cycle; the write wins over single done
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			meas_mode_config <= meas_mode_config_pkg::RST_MEAS_MODE_CFG;
		else
		begin
			if (wr_cfg)
				meas_mode_config <= wr_cfg_val;
			if (single_end && !wr_cfg)
				meas_mode_config.operating_mode_field
					<= meas_mode_config_pkg::OPM_IDLE;
			if (forced_end)
				meas_mode_config.baseline_comp_select
					<= meas_mode_config_pkg::BOC_AUTO;
			if (pwm_fall)
				meas_mode_config.pwm_sw_output_enable <= 1'b1;
		end
	end

	// ==========================================================
	// Communication error flag, set beats clear
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			comm_error_flag <= 1'b0;
		else if (comm_err_set)
			comm_error_flag <= 1'b1;
		else if (sts_clear)
			comm_error_flag <= 1'b0;
	end

	// ==========================================================
	// Active period, held while running
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			o_ACTIVE_PERIOD  <= meas_mode_config_pkg::PERIOD_MIN;
			o_PERIOD_LATCHED <= 1'b0;
		end
		else
		begin
			o_PERIOD_LATCHED <= enter_cont;
			if (enter_cont)
				o_ACTIVE_PERIOD <= sat_period;
		end
	end

	// ==========================================================
	// Read port
	logic [7:0] sts_view;
	logic [7:0] rd_mux;
	always_comb
	begin
		sts_view = 8'h00;
		sts_view[meas_mode_config_pkg::STS_PWM_PIN_BIT]  = pin_sync;
		sts_view[meas_mode_config_pkg::STS_COMM_ERR_BIT] = comm_error_flag;
		case (i_ADDR)
			meas_mode_config_pkg::ADDR_SENSOR_STATUS:  rd_mux = sts_view;
			meas_mode_config_pkg::ADDR_MEAS_PERIOD_HI: rd_mux = meas_period_high;
			meas_mode_config_pkg::ADDR_MEAS_PERIOD_LO: rd_mux = meas_period_low;
			meas_mode_config_pkg::ADDR_MEAS_MODE_CFG:  rd_mux = meas_mode_config;
			default:                           rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			o_RDATA  <= 8'h00;
			o_RVALID <= 1'b0;
		end
		else
		begin
			o_RVALID <= i_RD_EN;
			if (i_RD_EN)
				o_RDATA <= rd_mux;
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			o_SINGLE_TRIGGER <= 1'b0;
			o_OPERATING_MODE <= meas_mode_config_pkg::OPM_IDLE;
			o_BASELINE_COMP  <= meas_mode_config_pkg::BOC_AUTO;
			o_PWM_MODE       <= 1'b0;
			o_PWM_OUT_ENABLE <= 1'b0;
			o_COMM_ERROR     <= 1'b0;
		end
		else
		begin
			o_SINGLE_TRIGGER <= req_single;
			o_OPERATING_MODE <= meas_mode_config.operating_mode_field;
			o_BASELINE_COMP  <= meas_mode_config.baseline_comp_select;
			o_PWM_MODE       <= meas_mode_config.pwm_mode;
			// Pin high blocks output whatever software says
			o_PWM_OUT_ENABLE <= meas_mode_config.pwm_sw_output_enable
				&& !pin_sync;
			o_COMM_ERROR     <= comm_error_flag;
		end
	end

endmodule

`default_nettype wire

/* verif/meas_mode_config_regs_props.sv */
// Assertion checker for the measurement configuration registers
`timescale 1ns/100ps
`default_nettype none

module meas_mode_config_regs_props
(
	input wire logic        I_CLK,
	input wire logic        I_RESET_N,
	input wire logic        i_WR_EN,
	input wire logic        i_RD_EN,
	input wire logic [7:0]  i_ADDR,
	input wire logic [7:0]  i_WDATA,
	input wire logic        i_PWM_DISABLE_PIN,
	input wire logic        i_SINGLE_DONE,
	input wire logic        i_FORCED_COMP_DONE,
	input wire logic [7:0]  o_RDATA,
	input wire logic        o_RVALID,
	input wire logic [15:0] o_ACTIVE_PERIOD,
	input wire logic        o_PERIOD_LATCHED,
	input wire logic        o_SINGLE_TRIGGER,
	input wire logic [1:0]  o_OPERATING_MODE,
	input wire logic [1:0]  o_BASELINE_COMP,
	input wire logic        o_PWM_MODE,
	input wire logic        o_PWM_OUT_ENABLE,
	input wire logic        o_COMM_ERROR
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RESET_N);
	// ==========
	// Properties
	sequence s_cfg_wr;
		i_WR_EN && i_ADDR == 8'h04 ##1 !i_WR_EN;
	endsequence
	// No writes, so a later clear of bit 5 cannot hide the set
	sequence s_pin_fall;
		$fell(i_PWM_DISABLE_PIN) ##0 (!i_PWM_DISABLE_PIN && !i_WR_EN)[*7];
	endsequence
	property p_lo_err;
		i_WR_EN && i_ADDR == 8'h03 && i_WDATA < 8'h05 |-> ##2 o_COMM_ERROR;
	endproperty
	a_lo_err: assert property (p_lo_err) else $error("low byte");
	property p_hi_err;
		i_WR_EN && i_ADDR == 8'h02 && i_WDATA > 8'h0f |-> ##2 o_COMM_ERROR;
	endproperty
	a_hi_err: assert property (p_hi_err) else $error("high byte");
	property p_sticky;
		$fell(o_COMM_ERROR)
			|-> $past(i_WR_EN && i_ADDR == 8'h01 && i_WDATA[0], 2);
	endproperty
	a_sticky: assert property (p_sticky) else $error("err drop");
	property p_hold;
		!o_PERIOD_LATCHED |-> $stable(o_ACTIVE_PERIOD);
	endproperty
	a_hold: assert property (p_hold) else $error("period moved");
	property p_cause;
		o_PERIOD_LATCHED
			|-> $past(i_WR_EN && i_ADDR == 8'h04 && i_WDATA[1:0] == 2'h2);
	endproperty
	a_cause: assert property (p_cause) else $error("stray latch");
	property p_pin_off;
		i_PWM_DISABLE_PIN[*4] |-> !o_PWM_OUT_ENABLE;
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin off");
	property p_pin_fall;
		s_pin_fall |-> o_PWM_OUT_ENABLE;
	endproperty
	a_pin_fall: assert property (p_pin_fall) else $error("no set");
	property p_pwm_mode;
		s_cfg_wr |=> o_PWM_MODE == $past(i_WDATA[4], 2);
	endproperty
	a_pwm_mode: assert property (p_pwm_mode) else $error("pwm mode");
endmodule

bind meas_mode_config_regs meas_mode_config_regs_props u_props (.*);
`default_nettype wire

/* verif/reg_host.sv */
// Host model issuing byte register accesses
`timescale 1ns/100ps
`default_nettype none

module reg_host
(
	input  wire logic  i_clk,
	output logic       o_wr_en,
	output logic       o_rd_en,
	output logic [7:0] o_addr,
	output logic [7:0] o_wdata
);
	initial
	begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// Released bus shows inverted values, never a stale match
	task automatic drive(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_wr_en = w;
		o_rd_en = !w;
		o_addr = a;
		o_wdata = (a == 8'h04) ? (d & 8'h3f) : d;
		@(posedge i_clk);
		#1;
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = ~o_addr;
		o_wdata = ~o_wdata;
	endtask
endmodule
`default_nettype wire

/* verif/measurement_config_registers_tb.sv */
// Self-checking bench for the measurement configuration registers
`timescale 1ns/100ps
`default_nettype none

module measurement_config_registers_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        pin = 1'b0;
	logic        sdone = 1'b0;
	logic        fdone = 1'b0;
	logic        wr, rd_en, rv, lat, trig, pmode, pen, err;
	logic [7:0]  addr, wd, rdata, hi, lo;
	logic [15:0] per, ep;
	logic [1:0]  opm, boc;
	logic [7:0]  exp_q[$];
	logic [7:0]  th[5] = '{8'h00, 8'h01, 8'h0f, 8'h10, 8'hf0};
	logic [7:0]  tl[5] = '{8'h03, 8'h00, 8'hff, 8'h20, 8'h80};
	int          miscompares = 0;
	int          checks = 0;
	always #2 clk = ~clk;
	reg_host u_host (.i_clk(clk), .o_wr_en(wr), .o_rd_en(rd_en),
		.o_addr(addr), .o_wdata(wd));
	meas_mode_config_regs u_dut (.I_CLK(clk), .I_RESET_N(rst_n), .i_WR_EN(wr),
		.i_RD_EN(rd_en), .i_ADDR(addr), .i_WDATA(wd),
		.i_PWM_DISABLE_PIN(pin), .i_SINGLE_DONE(sdone),
		.i_FORCED_COMP_DONE(fdone), .o_RDATA(rdata), .o_RVALID(rv),
		.o_ACTIVE_PERIOD(per), .o_PERIOD_LATCHED(lat),
		.o_SINGLE_TRIGGER(trig), .o_OPERATING_MODE(opm),
		.o_BASELINE_COMP(boc), .o_PWM_MODE(pmode),
		.o_PWM_OUT_ENABLE(pen), .o_COMM_ERROR(err));
	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.drive(1'b0, a, 8'h00);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		u_host.drive(1'b1, a, d);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic report_and_stop();
		// A read that never answered counts as a miss
		if (exp_q.size() != 0)
			miscompares++;
		if (miscompares == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Read answers settle mid-cycle
	always @(negedge clk)
		if (rv === 1'b1)
			chk("rdata", exp_q.pop_front(), rdata);
	initial
	begin
		#40000;
		miscompares++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(24214));
		cyc(3);
		rst_n = 1'b1;
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h3c);
		rd(8'h04, 8'h24);
		rd(8'h09, 8'h00);
		chk("boc", 16'h1, boc);
		for (int i = 0; i < 8; i++)
		begin
			hi = (i < 5) ? th[i] : 8'($urandom_range(15, 0));
			lo = (i < 5) ? tl[i] : 8'($urandom_range(255, 0));
			wr_reg(8'h02, hi);
			wr_reg(8'h03, lo);
			ep = {hi, (lo < 8'h05) ? 8'h05 : lo};
			// Signed view, so negative periods go to the floor
			ep = ($signed(ep) > 16'sh0fff) ? 16'h0fff
				: ($signed(ep) < 16'sh0005) ? 16'h0005 : ep;
			rd(8'h03, (lo < 8'h05) ? 8'h05 : lo);
			rd(8'h01, {4'h0, hi > 8'h0f || lo < 8'h05, 3'h0});
			wr_reg(8'h01, 8'h01);
			rd(8'h01, 8'h00);
			wr_reg(8'h04, 8'h26);
			chk("lat", 16'h1, lat);
			chk("per", ep, per);
			wr_reg(8'h03, 8'h40);
			wr_reg(8'h04, 8'h26);
			chk("hold", ep, per);
			chk("opm", 16'h2, opm);
			wr_reg(8'h04, i[0] ? 8'h27 : 8'h24);
			// Late low write may flag again; start next pass clean
			wr_reg(8'h01, 8'h01);
		end
		wr_reg(8'h04, 8'h25);
		chk("trig", 16'h1, trig);
		sdone = 1'b1;
		cyc(1);
		sdone = 1'b0;
		rd(8'h04, 8'h24);
		wr_reg(8'h04, 8'h28);
		fdone = 1'b1;
		cyc(1);
		fdone = 1'b0;
		rd(8'h04, 8'h24);
		wr_reg(8'h04, 8'h10);
		cyc(2);
		chk("pmode", 16'h1, pmode);
		chk("pen", 16'h0, pen);
		pin = 1'b1;
		cyc(6);
		pin = 1'b0;
		cyc(8);
		chk("pen", 16'h1, pen);
		rd(8'h04, 8'h30);
		pin = 1'b1;
		cyc(6);
		chk("pen", 16'h0, pen);
		rd(8'h01, 8'h40);
		// Let the read answer be checked before reset kills it
		cyc(1);
		pin = 1'b0;
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		rd(8'h04, 8'h24);
		cyc(3);
		report_and_stop();
	end
endmodule
`default_nettype wire
